// >>> logic/ltpam_pkg.sv
// constants, register map and state codes for the address mapper
// assumes one 200 MHz clock domain and an AXI4-Lite register master
`default_nettype none

package ltpam_pkg;

    // mapping table geometry
    localparam int LA_W      = 17;
    localparam int PA_W      = 16;
    localparam int IDX_W     = 18;
    localparam int ENTRY_W   = 19;
    localparam int MEM_DEPTH = 262144;

    // entry fields; reverse entries hold the logical id in [LA_W-1:0]
    localparam int ENT_PAR   = 18;
    localparam int ENT_WATCH = 17;
    localparam int ENT_VALID = 16;
    localparam int REV_BIT   = 17;

    // register bus
    localparam int AXI_AW    = 21;
    localparam int AXI_DW    = 32;
    localparam int TABLE_SEL = 20;
    localparam logic [AXI_AW-1:0] OFF_CTRL     = 21'h00000;
    localparam logic [AXI_AW-1:0] OFF_STATUS   = 21'h00004;
    localparam logic [AXI_AW-1:0] OFF_MASK     = 21'h00008;
    localparam logic [AXI_AW-1:0] OFF_ERRLOC   = 21'h0000C;
    localparam logic [AXI_AW-1:0] OFF_WATCHLOC = 21'h00010;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // control bits
    localparam int CTRL_W  = 1;
    localparam int CTRL_EN = 0;
    localparam logic [CTRL_W-1:0] CTRL_RST = 1'h0;

    // status / mask bits
    localparam int ST_W      = 5;
    localparam int ST_MAPERR = 0;
    localparam int ST_RAMPAR = 1;
    localparam int ST_PBPAR  = 2;
    localparam int ST_UNMAP  = 3;
    localparam int ST_WATCH  = 4;
    localparam logic [ST_W-1:0] ST_RST = 5'h00;

    // refresh timing
    localparam int CLOCK_MHZ      = 200;
    localparam int REFRESH_NS     = 15600;
    localparam int REFRESH_CYCLES = (REFRESH_NS * CLOCK_MHZ) / 1000;
    localparam int REF_CNT_W      = 12;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_REFRESH = 5'h02,
        ST_PROC    = 5'h04,
        ST_MAP     = 5'h08,
        ST_CHECK   = 5'h10
    } ltpam_state_t;

endpackage : ltpam_pkg

`default_nettype wire

// >>> logic/ltpam_mapper.sv
// logical-to-physical address mapper for a packet bus, with its DRAM table,
// refresh, control sequencer, maintenance registers and AXI4-Lite slave
// assumes packet-bus address cycles and the clock share one domain
//
// Operation
// - address cycle comes first; data follows only after it
// - bypass cycle passes the address through as the location
// - assist cycle translates a logical id into a location
// - software marks ids for watching by a table entry bit
// - use of a watched id notifies the supervising processor
// - logical id register addresses the table
// - translated location register drives the bus address
// - continuous refresh rewrites the data it read
// - table address picks converted, logical, refresh or processor address
// - converted address fed back through the mux for checking
// - table is 256K entries of 19 bits
// - maintenance: enable, parity, mapping, unable-to-map errors, location, interrupt enables
// - sequencer runs refresh, processor, map and converted-address accesses
// - a map sequence starts a translation check only on a good valid entry with enable set, else it ends
// - processor sees the table as plain memory
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module ltpam_mapper
(
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    // register bus write
    input  wire logic [ltpam_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [ltpam_pkg::AXI_DW-1:0] s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // register bus read
    input  wire logic [ltpam_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [ltpam_pkg::AXI_DW-1:0]     s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // packet bus address cycle
    input  wire logic                        tbAddrCycle,
    input  wire logic                        tbAssist,
    input  wire logic [ltpam_pkg::LA_W-1:0]  tbAddr,
    output logic                             tbBusy,
    output logic [ltpam_pkg::PA_W-1:0]       tbLocAddr,
    output logic                             tbLocValid,
    output logic                             tbMapFail,
    // supervising processor notification
    output logic                             watchHit,
    output logic                             irq
);
    import ltpam_pkg::*;

    function automatic logic parityOk(input logic [ENTRY_W-1:0] e);
        parityOk = ~(^e);
    endfunction : parityOk

    function automatic logic [IDX_W-1:0] tableIdx(input logic [AXI_AW-1:0] a);
        tableIdx = a[IDX_W+1:2];
    endfunction : tableIdx

    // table storage
    logic [ENTRY_W-1:0] mem [MEM_DEPTH];

    ltpam_state_t           state_r;
    ltpam_state_t           state_nxt;
    logic                   awReady_r;
    logic                   wReady_r;
    logic                   bValid_r;
    logic [1:0]             bResp_r;
    logic                   arReady_r;
    logic                   rValid_r;
    logic [1:0]             rResp_r;
    logic [AXI_DW-1:0]      rData_r;
    logic [AXI_AW-1:0]      wAddr_r;
    logic [AXI_DW-1:0]      wData_r;
    logic [AXI_AW-1:0]      rAddr_r;
    logic [CTRL_W-1:0]      ctrl_r;
    logic [ST_W-1:0]        status_r;
    logic [ST_W-1:0]        mask_r;
    logic [LA_W-1:0]        errLoc_r;
    logic [LA_W-1:0]        watchLoc_r;
    logic [LA_W-1:0]        logical_r;
    logic                   watchMark_r;
    logic                   busy_r;
    logic [PA_W-1:0]        locAddr_r;
    logic                   locValid_r;
    logic                   mapFail_r;
    logic                   watchHit_r;
    logic                   irq_r;
    logic [REF_CNT_W-1:0]   refTimer_r;
    logic                   refPend_r;
    logic [IDX_W-1:0]       refAddr_r;

    logic                   wrPend;
    logic                   rdPend;
    logic                   wrTable;
    logic                   rdTable;
    logic                   wrBadPar;
    logic                   wrRegDone;
    logic                   rdRegDone;
    logic                   procReq;
    logic                   procWrite;
    logic [IDX_W-1:0]       procIdx;
    logic [IDX_W-1:0]       memAddr;
    logic [ENTRY_W-1:0]     memRd;
    logic                   wStrbHeld_r;
    logic [ST_W-1:0]        stSet;
    logic [ST_W-1:0]        stClr;
    logic [AXI_DW-1:0]      regRd;
    logic                   regHit;
    logic                   capture;
    logic                   mapOk;
    logic                   checkOk;

    assign s_axi_awready = awReady_r;
    assign s_axi_wready  = wReady_r;
    assign s_axi_bvalid  = bValid_r;
    assign s_axi_bresp   = bResp_r;
    assign s_axi_arready = arReady_r;
    assign s_axi_rvalid  = rValid_r;
    assign s_axi_rresp   = rResp_r;
    assign s_axi_rdata   = rData_r;
    assign tbBusy        = busy_r;
    assign tbLocAddr     = locAddr_r;
    assign tbLocValid    = locValid_r;
    assign tbMapFail     = mapFail_r;
    assign watchHit      = watchHit_r;
    assign irq           = irq_r;

    // bus request decode; table lives above the register window
    always_comb
    begin
        wrPend    = !awReady_r && !wReady_r && !bValid_r;
        rdPend    = !arReady_r && !rValid_r;
        wrTable   = wAddr_r[TABLE_SEL];
        rdTable   = rAddr_r[TABLE_SEL];
        wrBadPar  = wrPend && wrTable && !parityOk(wData_r[ENTRY_W-1:0]);
        wrRegDone = wrPend && (!wrTable || wrBadPar);
        rdRegDone = rdPend && !rdTable;
        procWrite = wrPend && wrTable && !wrBadPar;
        procReq   = procWrite || (rdPend && rdTable);
        procIdx   = procWrite ? tableIdx(wAddr_r) : tableIdx(rAddr_r);
        capture   = tbAddrCycle && !busy_r;
    end

    // register read mux
    always_comb
    begin
        regRd  = '0;
        regHit = 1'b1;
        unique case (rAddr_r)
            OFF_CTRL:     regRd[CTRL_W-1:0] = ctrl_r;
            OFF_STATUS:   regRd[ST_W-1:0]   = status_r;
            OFF_MASK:     regRd[ST_W-1:0]   = mask_r;
            OFF_ERRLOC:   regRd[LA_W-1:0]   = errLoc_r;
            OFF_WATCHLOC: regRd[LA_W-1:0]   = watchLoc_r;
            default:      regHit            = 1'b0;
        endcase
    end

    // sequencer: one access per state, refresh first
    always_comb
    begin
        state_nxt = ST_IDLE;
        unique case (state_r)
            ST_IDLE:
            begin
                if (refPend_r)
                    state_nxt = ST_REFRESH;
                else if (procReq)
                    state_nxt = ST_PROC;
                else if (busy_r)
                    state_nxt = ST_MAP;
            end
            ST_MAP:
                state_nxt = mapOk ? ST_CHECK : ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // table address select: exactly one source per state
    always_comb
    begin
        unique case (state_r)
            ST_REFRESH: memAddr = refAddr_r;
            ST_PROC:    memAddr = procIdx;
            ST_MAP:     memAddr = {1'b0, logical_r};
            ST_CHECK:   memAddr = {1'b1, 1'b0, locAddr_r};
            default:    memAddr = refAddr_r;
        endcase
    end

    // async read of the flop array; refresh writes back what it read
    always_comb
    begin
        memRd   = mem[memAddr];
        mapOk   = parityOk(memRd) && memRd[ENT_VALID] && ctrl_r[CTRL_EN];
        checkOk = parityOk(memRd) && (memRd[LA_W-1:0] == logical_r);
    end

    // no reset on the array: contents are software-owned
    always_ff @(posedge clock)
    begin
        if (state_r == ST_REFRESH)
            mem[memAddr] <= memRd;
        else if (state_r == ST_PROC && procWrite)
            mem[memAddr] <= wData_r[ENTRY_W-1:0];
    end

    // refresh timer and address
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            refTimer_r <= '0;
            refPend_r  <= 1'b0;
            refAddr_r  <= '0;
        end
        else
        begin
            refTimer_r <= refTimer_r + REF_CNT_W'(1);
            if (state_r == ST_REFRESH)
            begin
                refPend_r <= 1'b0;
                refAddr_r <= refAddr_r + IDX_W'(1);
            end
            if (refTimer_r == REF_CNT_W'(REFRESH_CYCLES - 1))
            begin
                refTimer_r <= '0;
                refPend_r  <= 1'b1;
            end
        end
    end

    // write channel: hold address and data until the response is taken
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awReady_r <= 1'b1;
            wReady_r  <= 1'b1;
            bValid_r  <= 1'b0;
            bResp_r   <= RESP_OKAY;
            wAddr_r   <= '0;
            wData_r   <= '0;
        end
        else
        begin
            if (awReady_r && s_axi_awvalid)
            begin
                awReady_r <= 1'b0;
                wAddr_r   <= s_axi_awaddr;
            end
            if (wReady_r && s_axi_wvalid)
            begin
                wReady_r <= 1'b0;
                wData_r  <= s_axi_wdata;
            end
            if (wrRegDone || (state_r == ST_PROC && procWrite))
            begin
                bValid_r <= 1'b1;
                bResp_r  <= (wrBadPar || (!wrTable && !(wAddr_r inside {OFF_CTRL, OFF_STATUS,
                            OFF_MASK, OFF_ERRLOC, OFF_WATCHLOC}))) ? RESP_SLVERR : RESP_OKAY;
            end
            if (bValid_r && s_axi_bready)
            begin
                bValid_r  <= 1'b0;
                awReady_r <= 1'b1;
                wReady_r  <= 1'b1;
            end
        end
    end

    // read channel
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arReady_r <= 1'b1;
            rValid_r  <= 1'b0;
            rResp_r   <= RESP_OKAY;
            rData_r   <= '0;
            rAddr_r   <= '0;
        end
        else
        begin
            if (arReady_r && s_axi_arvalid)
            begin
                arReady_r <= 1'b0;
                rAddr_r   <= s_axi_araddr;
            end
            if (rdRegDone)
            begin
                rValid_r <= 1'b1;
                rData_r  <= regRd;
                rResp_r  <= regHit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (state_r == ST_PROC && !procWrite)
            begin
                rValid_r <= 1'b1;
                rData_r  <= AXI_DW'(memRd);
                rResp_r  <= RESP_OKAY;
            end
            if (rValid_r && s_axi_rready)
            begin
                rValid_r  <= 1'b0;
                arReady_r <= 1'b1;
            end
        end
    end

    // control and mask; only byte lane 0 carries bits
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= CTRL_RST;
            mask_r <= ST_RST;
        end
        else if (wrRegDone && !wrTable && wStrbHeld_r)
        begin
            if (wAddr_r == OFF_CTRL)
                ctrl_r <= wData_r[CTRL_W-1:0];
            if (wAddr_r == OFF_MASK)
                mask_r <= wData_r[ST_W-1:0];
        end
    end

    // strobe travels with the data beat
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            wStrbHeld_r <= 1'b0;
        else if (wReady_r && s_axi_wvalid)
            wStrbHeld_r <= s_axi_wstrb[0];
    end

    // address cycle capture and translation results
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_r      <= 1'b0;
            logical_r   <= '0;
            watchMark_r <= 1'b0;
            locAddr_r   <= '0;
            locValid_r  <= 1'b0;
            mapFail_r   <= 1'b0;
            watchHit_r  <= 1'b0;
        end
        else
        begin
            locValid_r <= 1'b0;
            mapFail_r  <= 1'b0;
            watchHit_r <= 1'b0;
            if (capture && !tbAssist)
            begin
                locAddr_r  <= tbAddr[PA_W-1:0];
                locValid_r <= 1'b1;
            end
            else if (capture)
            begin
                logical_r <= tbAddr;
                busy_r    <= 1'b1;
            end
            if (state_r == ST_MAP)
            begin
                if (mapOk)
                begin
                    locAddr_r   <= memRd[PA_W-1:0];
                    watchMark_r <= memRd[ENT_WATCH];
                end
                else
                begin
                    busy_r    <= 1'b0;
                    mapFail_r <= 1'b1;
                end
            end
            if (state_r == ST_CHECK)
            begin
                busy_r     <= 1'b0;
                locValid_r <= checkOk;
                mapFail_r  <= !checkOk;
                watchHit_r <= checkOk && watchMark_r;
            end
        end
    end

    // maintenance events; a read of status clears, a new event wins
    always_comb
    begin
        stSet = '0;
        stClr = '0;
        if ((state_r == ST_MAP || state_r == ST_CHECK) && !parityOk(memRd))
            stSet[ST_RAMPAR] = 1'b1;
        if (state_r == ST_MAP && !mapOk && !stSet[ST_RAMPAR])
            stSet[ST_UNMAP] = 1'b1;
        if (state_r == ST_CHECK && parityOk(memRd) && !checkOk)
            stSet[ST_MAPERR] = 1'b1;
        if (state_r == ST_CHECK && checkOk && watchMark_r)
            stSet[ST_WATCH] = 1'b1;
        if (wrBadPar)
            stSet[ST_PBPAR] = 1'b1;
        if (rdRegDone && rAddr_r == OFF_STATUS)
            stClr = '1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_r   <= ST_RST;
            errLoc_r   <= '0;
            watchLoc_r <= '0;
            irq_r      <= 1'b0;
        end
        else
        begin
            status_r <= (status_r & ~stClr) | stSet;
            if (wrBadPar)
                errLoc_r <= LA_W'(tableIdx(wAddr_r));
            else if (|stSet[ST_UNMAP:ST_MAPERR])
                errLoc_r <= logical_r;
            if (stSet[ST_WATCH])
                watchLoc_r <= logical_r;
            irq_r <= |(status_r & mask_r);
        end
    end

endmodule : ltpam_mapper

`default_nettype wire

// >>> tb/ltpam_checker.sv
// port assertions for the mapper: packet-bus answers and register-bus holds
// assumes one clock domain; bound to every ltpam_mapper instance below
`timescale 1ns/1ps
`default_nettype none

module ltpam_checker
(
    // clock and reset
    input wire logic                         clock,
    input wire logic                         rst_n,
    // packet bus
    input wire logic                         tbAddrCycle,
    input wire logic                         tbAssist,
    input wire logic [ltpam_pkg::LA_W-1:0]   tbAddr,
    input wire logic                         tbBusy,
    input wire logic [ltpam_pkg::PA_W-1:0]   tbLocAddr,
    input wire logic                         tbLocValid,
    input wire logic                         tbMapFail,
    input wire logic                         watchHit,
    // register bus answers
    input wire logic                         s_axi_bvalid,
    input wire logic                         s_axi_bready,
    input wire logic [1:0]                   s_axi_bresp,
    input wire logic                         s_axi_rvalid,
    input wire logic                         s_axi_rready,
    input wire logic [ltpam_pkg::AXI_DW-1:0] s_axi_rdata
);
    import ltpam_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_bypass_pass: assert property (tbAddrCycle && !tbAssist && !tbBusy |=>
        tbLocValid && tbLocAddr == PA_W'($past(tbAddr))) else $error("bypass result wrong");
    chk_assist_take: assert property (tbAddrCycle && tbAssist && !tbBusy |=> tbBusy)
        else $error("assist cycle not captured");
    // idle, map and check each take a cycle; refresh may stretch it
    chk_map_span: assert property ($rose(tbBusy) |-> tbBusy[*2] ##[1:40] !tbBusy)
        else $error("translation span out of bounds");
    chk_one_result: assert property ($fell(tbBusy) |-> tbLocValid != tbMapFail)
        else $error("translation ended without one result");
    chk_fail_pulse: assert property (tbMapFail |=> !tbMapFail)
        else $error("fail pulse too long");
    chk_watch_ok: assert property (watchHit |-> tbLocValid || $past(tbLocValid))
        else $error("watch hit without a translation");
    chk_loc_stands: assert property ($changed(tbLocAddr) |-> tbLocValid || tbBusy)
        else $error("location changed outside a result");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule : ltpam_checker

bind ltpam_mapper ltpam_checker i_chk (.*);

`default_nettype wire

// >>> tb/ltpam_tbus_model.sv
// packet-bus source: presents address cycles and collects the mapper's answer
// assumes the bench calls send() from one process at a time
`timescale 1ns/1ps
`default_nettype none

module ltpam_tbus_model
(
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    // address cycle to the mapper
    output logic                            tbAddrCycle,
    output logic                            tbAssist,
    output logic [ltpam_pkg::LA_W-1:0]      tbAddr,
    // answer from the mapper
    input  wire logic                       tbBusy,
    input  wire logic [ltpam_pkg::PA_W-1:0] tbLocAddr,
    input  wire logic                       tbLocValid,
    input  wire logic                       tbMapFail
);
    import ltpam_pkg::*;
    initial
    begin
        tbAddrCycle = 1'b0;
        tbAssist    = 1'b0;
        tbAddr      = '0;
    end

    // data would follow only after a location came back
    task automatic send(input logic a, input logic [LA_W-1:0] d,
                        output logic [PA_W-1:0] loc, output logic ok);
        int n;
        @(posedge clock);
        tbAddrCycle <= 1'b1;
        tbAssist    <= a;
        tbAddr      <= d;
        do @(posedge clock); while (tbBusy !== 1'b0);
        tbAddrCycle <= 1'b0;
        // released lines must not echo the old id
        tbAddr      <= ~d;
        for (n = 0; n < 60; n++)
        begin
            @(posedge clock);
            if (tbLocValid === 1'b1 || tbMapFail === 1'b1)
                break;
        end
        ok  = tbLocValid;
        loc = tbLocAddr;
    endtask : send
endmodule : ltpam_tbus_model

`default_nettype wire

// >>> tb/ltpam_mapper_tb.sv
// self-checking bench: registers, table and packet-bus translations
// assumes the bound checker and the packet-bus model beside the mapper
`timescale 1ns/1ps
`default_nettype none

module ltpam_mapper_tb;
    import ltpam_pkg::*;
    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
    logic [AXI_DW-1:0] wdata = '0, rdata;
    logic [3:0]        wstrb = 4'hF;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic              arvalid = 1'b0, rready = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic              tbAddrCycle, tbAssist, tbBusy, tbLocValid, tbMapFail, watchHit, irq;
    logic [LA_W-1:0]   tbAddr;
    logic [PA_W-1:0]   tbLocAddr;
    int                num_errors = 0;
    int                checks_done = 0;
    int                hits = 0;

    ltpam_mapper i_dut (.clock, .rst_n, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tbAddrCycle,
        .tbAssist, .tbAddr, .tbBusy, .tbLocAddr, .tbLocValid, .tbMapFail, .watchHit, .irq);
    ltpam_tbus_model i_tbus (.clock, .rst_n, .tbAddrCycle, .tbAssist, .tbAddr, .tbBusy,
        .tbLocAddr, .tbLocValid, .tbMapFail);

    always #2.5 clock = ~clock;
    always @(posedge clock) if (watchHit === 1'b1) hits <= hits + 1;

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d,
                          input logic [1:0] e = RESP_OKAY);
        @(posedge clock);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clock);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        check(32'(bresp), 32'(e), "write response");
        bready <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [AXI_AW-1:0] a, input logic [31:0] m,
                          input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
        @(posedge clock);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge clock);
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        check(rdata & m, e, "read data");
        check(32'(rresp), 32'(er), "read response");
        rready <= 1'b0;
    endtask : reg_rd

    function automatic logic [AXI_AW-1:0] tab(input logic [IDX_W-1:0] i);
        return {1'b1, i, 2'b00};
    endfunction : tab

    // even parity over the 19 stored bits
    function automatic logic [31:0] ent(input logic [ENTRY_W-2:0] x);
        return {13'h0000, ^x, x};
    endfunction : ent

    task automatic setmap(input logic [LA_W-1:0] lid, input logic [PA_W-1:0] loc,
                          input logic [LA_W-1:0] back, input logic w);
        reg_wr(tab({1'b0, lid}), ent({w, 1'b1, loc}));
        reg_wr(tab({2'b10, loc}), ent({1'b0, back}));
    endtask : setmap

    task automatic xl(input logic a, input logic [LA_W-1:0] d, input logic eok,
                      input logic [PA_W-1:0] eloc);
        logic [PA_W-1:0] loc;
        logic            ok;
        i_tbus.send(a, d, loc, ok);
        check(32'(ok), 32'(eok), "result kind");
        if (eok)
            check(32'(loc), 32'(eloc), "location");
    endtask : xl

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        reg_rd(OFF_CTRL, '1, 32'h0);
        reg_rd(OFF_STATUS, '1, 32'h0);
        reg_rd(OFF_MASK, '1, 32'h0);
        reg_rd(21'h00014, '1, 32'h0, RESP_SLVERR);
        reg_wr(21'h00018, 32'h1, RESP_SLVERR);
        check(32'(irq), 32'h0, "irq after reset");
        $display("test reset done");
        xl(1'b0, 17'h1A5C3, 1'b1, 16'hA5C3);
        xl(1'b1, 17'h00123, 1'b0, '0);
        reg_rd(OFF_STATUS, 32'h8, 32'h8);
        reg_rd(OFF_STATUS, 32'h1F, 32'h0);
        reg_rd(OFF_ERRLOC, 32'h1FFFF, 32'h123);
        $display("test disabled done");
        reg_wr(OFF_CTRL, 32'h1);
        reg_wr(OFF_MASK, 32'h1F);
        reg_rd(OFF_MASK, '1, 32'h1F);
        setmap(17'h1FFFF, 16'h4567, 17'h1FFFF, 1'b0);
        reg_rd(tab(18'h1FFFF), '1, ent({2'b01, 16'h4567}));
        xl(1'b1, 17'h1FFFF, 1'b1, 16'h4567);
        xl(1'b0, 17'h00321, 1'b1, 16'h0321);
        $display("test assist done");
        setmap(17'h00042, 16'h0100, 17'h00042, 1'b1);
        xl(1'b1, 17'h00042, 1'b1, 16'h0100);
        repeat (2) @(posedge clock);
        check(hits, 1, "watch pulses");
        check(32'(irq), 32'h1, "irq on watch");
        reg_rd(OFF_WATCHLOC, 32'h1FFFF, 32'h42);
        reg_wr(OFF_MASK, 32'h0);
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h0, "irq masked");
        reg_wr(OFF_MASK, 32'h1F);
        reg_rd(OFF_STATUS, 32'h10, 32'h10);
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h0, "irq cleared");
        $display("test watch done");
        setmap(17'h00077, 16'h0200, 17'h00078, 1'b0);
        xl(1'b1, 17'h00077, 1'b0, '0);
        reg_rd(OFF_STATUS, 32'h1, 32'h1);
        reg_rd(OFF_ERRLOC, 32'h1FFFF, 32'h77);
        reg_wr(tab(18'h00000), ent({2'b00, 16'h0300}));
        xl(1'b1, 17'h00000, 1'b0, '0);
        reg_rd(OFF_STATUS, 32'h8, 32'h8);
        reg_wr(tab(18'h00009), 32'h00000001, RESP_SLVERR);
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h1, "irq on parity");
        reg_rd(OFF_STATUS, 32'h4, 32'h4);
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h0, "irq after clear");
        $display("test errors done");
        // idle until refresh has rewritten entry 0
        repeat (REFRESH_CYCLES + 200) @(posedge clock);
        xl(1'b1, 17'h1FFFF, 1'b1, 16'h4567);
        reg_rd(tab(18'h00000), '1, ent({2'b00, 16'h0300}));
        $display("test refresh done");
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        num_errors++;
        $display("ERROR %0t: watchdog expired", $time);
        complete_run();
    end
endmodule : ltpam_mapper_tb

`default_nettype wire
